// ==== include/sfn_consts.vh ====
// Field positions, timing constants and codes of the synthesizer program registers
`ifndef SFN_CONSTS_VH
`define SFN_CONSTS_VH
`define SFN_WORD_BITS 24
`define SFN_ADDR_INT_FRACTIONAL_NUMERATOR 2'h0
`define SFN_ADDR_REF_MOD 2'h1
`define SFN_ADDR_CONTROL 2'h2
`define SFN_ADDR_NOISE 2'h3
`define SFN_FAST_LOCK_BIT 23
`define SFN_INT_MSB 22
`define SFN_INT_LSB 14
`define SFN_FRACTIONAL_NUMERATOR_MSB 13
`define SFN_FRACTIONAL_NUMERATOR_LSB 2
`define SFN_LOAD_CTRL_BIT 23
`define SFN_MON_SEL_MSB 22
`define SFN_MON_SEL_LSB 20
`define SFN_PRESCALER_BIT 18
`define SFN_RDIV_MSB 17
`define SFN_RDIV_LSB 14
`define SFN_MOD_MSB 13
`define SFN_MOD_LSB 2
`define SFN_CNT_RESET_BIT 2
`define SFN_CP_TRISTATE_BIT 3
`define SFN_POWER_DOWN_BIT 4
`define SFN_LOCK_PREC_BIT 5
`define SFN_PD_POLARITY_BIT 6
`define SFN_CP_CUR_MSB 10
`define SFN_CP_CUR_LSB 7
`define SFN_DOUBLER_BIT 11
`define SFN_NOISE_MSB 10
`define SFN_NOISE_LSB 2
`define SFN_NOISE_LOWEST_SPUR 9'h000
`define SFN_NOISE_LOWEST_NOISE 9'h0F1
`define SFN_MON_OFF 3'h0
`define SFN_MON_LOCK 3'h1
`define SFN_MON_REF_DIV 3'h2
`define SFN_MON_FB_DIV 3'h3
`define SFN_MON_FAST_LOCK 3'h6
`define SFN_LOCK_COUNT_LOW 6'h18
`define SFN_LOCK_COUNT_HIGH 6'h28
`define SFN_CLOCK_MHZ 100
`define SFN_LOCK_WINDOW_NS 15
`define SFN_UNLOCK_ERROR_NS 30
`define SFN_LOCK_WINDOW_CYC ((`SFN_LOCK_WINDOW_NS * `SFN_CLOCK_MHZ) / 1000)
`define SFN_UNLOCK_ERROR_CYC ((`SFN_UNLOCK_ERROR_NS * `SFN_CLOCK_MHZ + 999) / 1000)
`endif

// ==== hdl/sfn_program_registers.v ====
// Serial program registers and digital control of a fractional-N synthesizer
`include "sfn_consts.vh"
`default_nettype none
module sfn_program_registers #(
    parameter INT_WIDTH = 9,
    parameter FRACTIONAL_NUMERATOR_WIDTH = 12,
    parameter RDIV_WIDTH = 4
) (
    input wire i_clock,
    input wire i_reset,
    input wire i_serial_clock,
    input wire i_serial_data,
    input wire i_load_enable,
    input wire i_reference_input,
    input wire i_rf_feedback_input,
    output reg o_charge_pump_up,
    output reg o_charge_pump_down,
    output reg o_charge_pump_oe,
    output reg [3:0] o_charge_pump_current,
    output reg o_charge_pump_boost,
    output reg o_charge_pump_noise_bias,
    output reg o_dither_enable,
    output reg o_prescaler_select,
    output reg o_power_down,
    output reg o_lock_detect,
    output reg o_monitor_output
);
    // Pin synchronisers: serial clock, data, load, reference, rf
    reg [4:0] sync_a;
    reg [4:0] sync_b;
    reg [4:0] sync_c;
    reg [4:0] pin_level;
    reg [4:0] pin_prev;
    wire [4:0] pin_rise = pin_level & ~pin_prev;
    wire [4:0] pin_fall = ~pin_level & pin_prev;
    wire [4:0] next_pin_level = (sync_b & ~(sync_b ^ sync_c)) | (pin_level & (sync_b ^ sync_c));

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
            sync_c <= 5'h00;
            pin_level <= 5'h00;
            pin_prev <= 5'h00;
        end else begin
            sync_a <= {i_rf_feedback_input, i_reference_input, i_load_enable,
                       i_serial_data, i_serial_clock};
            sync_b <= sync_a;
            sync_c <= sync_b;
            pin_level <= next_pin_level;
            pin_prev <= pin_level;
        end
    end

    // Serial input register and word transfer
    reg [23:0] shift_word;
    reg [INT_WIDTH-1:0] int_value;
    reg [FRACTIONAL_NUMERATOR_WIDTH-1:0] fractional_numerator_value;
    reg [FRACTIONAL_NUMERATOR_WIDTH-1:0] modulus_pending;
    reg [FRACTIONAL_NUMERATOR_WIDTH-1:0] modulus_active;
    reg [FRACTIONAL_NUMERATOR_WIDTH-1:0] fast_lock_timer;
    reg fast_lock_request;
    reg [2:0] monitor_select;
    reg [RDIV_WIDTH-1:0] rdiv_value;
    reg [11:0] control_word;
    reg [8:0] noise_mode;
    reg channel_written;
    wire load_strobe = pin_rise[2];

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            shift_word <= 24'h000000;
            int_value <= {INT_WIDTH{1'b0}};
            fractional_numerator_value <= {FRACTIONAL_NUMERATOR_WIDTH{1'b0}};
            modulus_pending <= {FRACTIONAL_NUMERATOR_WIDTH{1'b0}};
            modulus_active <= {FRACTIONAL_NUMERATOR_WIDTH{1'b0}};
            fast_lock_timer <= {FRACTIONAL_NUMERATOR_WIDTH{1'b0}};
            fast_lock_request <= 1'b0;
            monitor_select <= 3'h0;
            rdiv_value <= {RDIV_WIDTH{1'b0}};
            o_prescaler_select <= 1'b0;
            control_word <= 12'h000;
            noise_mode <= 9'h000;
            channel_written <= 1'b0;
        end else begin
            channel_written <= 1'b0;
            if (pin_rise[0]) begin
                shift_word <= {shift_word[22:0], pin_level[1]};
            end
            // Registers keep loading during power-down
            if (load_strobe) begin
                case (shift_word[1:0])
                    `SFN_ADDR_INT_FRACTIONAL_NUMERATOR: begin
                        int_value <= shift_word[`SFN_INT_MSB:`SFN_INT_LSB];
                        fractional_numerator_value <= shift_word[`SFN_FRACTIONAL_NUMERATOR_MSB:`SFN_FRACTIONAL_NUMERATOR_LSB];
                        fast_lock_request <= shift_word[`SFN_FAST_LOCK_BIT];
                        modulus_active <= modulus_pending;
                        channel_written <= 1'b1;
                    end
                    `SFN_ADDR_REF_MOD: begin
                        if (shift_word[`SFN_LOAD_CTRL_BIT]) begin
                            fast_lock_timer <= shift_word[`SFN_MOD_MSB:`SFN_MOD_LSB];
                        end else begin
                            modulus_pending <= shift_word[`SFN_MOD_MSB:`SFN_MOD_LSB];
                        end
                        monitor_select <= shift_word[`SFN_MON_SEL_MSB:`SFN_MON_SEL_LSB];
                        o_prescaler_select <= shift_word[`SFN_PRESCALER_BIT];
                        rdiv_value <= shift_word[`SFN_RDIV_MSB:`SFN_RDIV_LSB];
                    end
                    `SFN_ADDR_CONTROL: begin
                        control_word <= shift_word[11:0];
                    end
                    default: begin
                        noise_mode <= shift_word[`SFN_NOISE_MSB:`SFN_NOISE_LSB];
                    end
                endcase
            end
        end
    end

    wire counter_reset = control_word[`SFN_CNT_RESET_BIT];
    wire power_down = control_word[`SFN_POWER_DOWN_BIT];
    wire hold_counters = counter_reset | power_down;
    wire doubler = control_word[`SFN_DOUBLER_BIT];

    // Reference divider; a ratio of zero is treated as one
    reg [RDIV_WIDTH-1:0] ref_count;
    reg ref_pulse;
    wire ref_edge = doubler ? (pin_rise[3] | pin_fall[3]) : pin_fall[3];
    wire [RDIV_WIDTH-1:0] ref_last = (rdiv_value == {RDIV_WIDTH{1'b0}}) ?
        {{(RDIV_WIDTH-1){1'b0}}, 1'b1} : rdiv_value;

    // Feedback divider: INT or INT+1 chosen by a fraction accumulator
    reg [INT_WIDTH:0] fb_count;
    reg [FRACTIONAL_NUMERATOR_WIDTH-1:0] fractional_numerator_acc;
    reg fb_pulse;
    wire [FRACTIONAL_NUMERATOR_WIDTH:0] acc_sum = {1'b0, fractional_numerator_acc} + {1'b0, fractional_numerator_value};
    wire acc_carry = (modulus_active != {FRACTIONAL_NUMERATOR_WIDTH{1'b0}}) &&
        (acc_sum >= {1'b0, modulus_active});
    wire [INT_WIDTH:0] fb_ratio = {1'b0, int_value} + {{INT_WIDTH{1'b0}}, acc_carry};

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ref_count <= {RDIV_WIDTH{1'b0}};
            ref_pulse <= 1'b0;
            fb_count <= {(INT_WIDTH+1){1'b0}};
            fractional_numerator_acc <= {FRACTIONAL_NUMERATOR_WIDTH{1'b0}};
            fb_pulse <= 1'b0;
        end else if (hold_counters) begin
            // Load state: counters restart cleanly once released
            ref_count <= {RDIV_WIDTH{1'b0}};
            ref_pulse <= 1'b0;
            fb_count <= {(INT_WIDTH+1){1'b0}};
            fractional_numerator_acc <= {FRACTIONAL_NUMERATOR_WIDTH{1'b0}};
            fb_pulse <= 1'b0;
        end else begin
            ref_pulse <= 1'b0;
            fb_pulse <= 1'b0;
            if (ref_edge) begin
                if (ref_count + {{(RDIV_WIDTH-1){1'b0}}, 1'b1} >= ref_last) begin
                    ref_count <= {RDIV_WIDTH{1'b0}};
                    ref_pulse <= 1'b1;
                end else begin
                    ref_count <= ref_count + {{(RDIV_WIDTH-1){1'b0}}, 1'b1};
                end
            end
            if (pin_rise[4]) begin
                if (fb_count + {{INT_WIDTH{1'b0}}, 1'b1} >= fb_ratio) begin
                    fb_count <= {(INT_WIDTH+1){1'b0}};
                    fb_pulse <= 1'b1;
                    fractional_numerator_acc <= acc_carry ? acc_sum[FRACTIONAL_NUMERATOR_WIDTH-1:0] - modulus_active :
                        acc_sum[FRACTIONAL_NUMERATOR_WIDTH-1:0];
                end else begin
                    fb_count <= fb_count + {{INT_WIDTH{1'b0}}, 1'b1};
                end
            end
        end
    end

    // Phase detector: error is the clock count between the two edges
    localparam PH_IDLE = 3'b001;
    localparam PH_REF_FIRST = 3'b010;
    localparam PH_FB_FIRST = 3'b100;
    reg [2:0] ph_state;
    reg [7:0] err_count;
    reg [5:0] good_count;
    reg err_done;
    wire [5:0] lock_target = control_word[`SFN_LOCK_PREC_BIT] ?
        `SFN_LOCK_COUNT_HIGH : `SFN_LOCK_COUNT_LOW;
    wire in_window = err_count < `SFN_LOCK_WINDOW_CYC;
    wire too_late = err_count > `SFN_UNLOCK_ERROR_CYC;

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ph_state <= PH_IDLE;
            err_count <= 8'h00;
            err_done <= 1'b0;
        end else if (hold_counters) begin
            ph_state <= PH_IDLE;
            err_count <= 8'h00;
            err_done <= 1'b0;
        end else begin
            err_done <= 1'b0;
            case (ph_state)
                PH_IDLE: begin
                    err_count <= 8'h00;
                    if (ref_pulse && fb_pulse) begin
                        err_done <= 1'b1;
                    end else if (ref_pulse) begin
                        ph_state <= PH_REF_FIRST;
                    end else if (fb_pulse) begin
                        ph_state <= PH_FB_FIRST;
                    end
                end
                PH_REF_FIRST, PH_FB_FIRST: begin
                    if (err_count != 8'hFF) begin
                        err_count <= err_count + 8'h01;
                    end
                    if ((ph_state == PH_REF_FIRST) ? fb_pulse : ref_pulse) begin
                        err_done <= 1'b1;
                        ph_state <= PH_IDLE;
                    end
                end
                default: begin
                    ph_state <= PH_IDLE;
                end
            endcase
        end
    end

    // Lock detect, fast-lock timer and registered outputs
    reg [FRACTIONAL_NUMERATOR_WIDTH-1:0] boost_count;
    wire up_raw = (ph_state == PH_REF_FIRST);
    wire down_raw = (ph_state == PH_FB_FIRST);
    wire positive_slope = control_word[`SFN_PD_POLARITY_BIT];

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            good_count <= 6'h00;
            o_lock_detect <= 1'b0;
            boost_count <= {FRACTIONAL_NUMERATOR_WIDTH{1'b0}};
            o_charge_pump_boost <= 1'b0;
            o_charge_pump_up <= 1'b0;
            o_charge_pump_down <= 1'b0;
            o_charge_pump_oe <= 1'b0;
            o_charge_pump_current <= 4'h0;
            o_charge_pump_noise_bias <= 1'b0;
            o_dither_enable <= 1'b0;
            o_power_down <= 1'b0;
            o_monitor_output <= 1'b0;
        end else begin
            if (power_down || channel_written) begin
                good_count <= 6'h00;
                o_lock_detect <= 1'b0;
            end else if (err_done) begin
                if (too_late) begin
                    o_lock_detect <= 1'b0;
                end
                if (in_window) begin
                    if (good_count + 6'h01 >= lock_target) begin
                        o_lock_detect <= 1'b1;
                    end
                    if (good_count != 6'h3F) begin
                        good_count <= good_count + 6'h01;
                    end
                end else begin
                    good_count <= 6'h00;
                end
            end
            // Timer restarts on each divider write with fast lock set
            if (channel_written && fast_lock_request) begin
                boost_count <= fast_lock_timer;
            end else if (ref_pulse && boost_count != {FRACTIONAL_NUMERATOR_WIDTH{1'b0}}) begin
                boost_count <= boost_count - {{(FRACTIONAL_NUMERATOR_WIDTH-1){1'b0}}, 1'b1};
            end
            o_charge_pump_boost <= (boost_count != {FRACTIONAL_NUMERATOR_WIDTH{1'b0}}) && !power_down;
            o_charge_pump_up <= positive_slope ? up_raw : down_raw;
            o_charge_pump_down <= positive_slope ? down_raw : up_raw;
            o_charge_pump_oe <= !control_word[`SFN_CP_TRISTATE_BIT] && !power_down;
            o_charge_pump_current <= control_word[`SFN_CP_CUR_MSB:`SFN_CP_CUR_LSB];
            o_dither_enable <= (noise_mode == `SFN_NOISE_LOWEST_SPUR);
            o_charge_pump_noise_bias <= (noise_mode == `SFN_NOISE_LOWEST_NOISE);
            o_power_down <= power_down;
            case (monitor_select)
                `SFN_MON_LOCK: o_monitor_output <= o_lock_detect;
                `SFN_MON_REF_DIV: o_monitor_output <= ref_pulse;
                `SFN_MON_FB_DIV: o_monitor_output <= fb_pulse;
                `SFN_MON_FAST_LOCK: o_monitor_output <= (boost_count != {FRACTIONAL_NUMERATOR_WIDTH{1'b0}});
                default: o_monitor_output <= 1'b0;
            endcase
        end
    end
endmodule // sfn_program_registers
`default_nettype wire

// ==== dv/sfn_program_registers_chk.sv ====
// Concurrent property checker bound to the synthesizer program register block
`default_nettype none
module sfn_program_registers_chk (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_reference_input,
    input wire logic i_load_enable,
    input wire logic o_charge_pump_oe,
    input wire logic [3:0] o_charge_pump_current,
    input wire logic o_charge_pump_boost,
    input wire logic o_charge_pump_noise_bias,
    input wire logic o_dither_enable,
    input wire logic o_prescaler_select,
    input wire logic o_power_down,
    input wire logic o_lock_detect
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] since_load;
    logic [5:0] ref_edges;
    logic ref_q;
    logic load_q;
    // Raw pin edges are seen before the design's filter, so these bounds are generous
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            since_load <= 5'h1F;
            ref_edges <= 6'h00;
            ref_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            load_q <= i_load_enable;
            ref_q <= i_reference_input;
            since_load <= (i_load_enable && !load_q) ? 5'h00 :
                (since_load == 5'h1F) ? since_load : since_load + 5'h01;
            ref_edges <= o_power_down ? 6'h00 :
                (ref_q && !i_reference_input && ref_edges != 6'h3F) ? ref_edges + 6'h01 :
                ref_edges;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    property p_pd_pump_off;
        o_power_down [*2] |-> !o_charge_pump_oe;
    endproperty
    property p_pd_no_lock;
        o_power_down [*2] |-> !o_lock_detect;
    endproperty
    // Doubler may give one pulse per edge, so twelve falling edges is the floor
    property p_lock_needs_ref;
        $rose(o_lock_detect) |-> ref_edges >= 6'h0C;
    endproperty
    property p_bias_no_dither;
        o_charge_pump_noise_bias [*2] |-> !o_dither_enable;
    endproperty
    property p_current_on_load;
        !$stable(o_charge_pump_current) |-> since_load < 5'h10;
    endproperty
    property p_prescaler_on_load;
        !$stable(o_prescaler_select) |-> since_load < 5'h10;
    endproperty
    property p_pd_on_load;
        !$stable(o_power_down) |-> since_load < 5'h10;
    endproperty
    property p_boost_on_load;
        $rose(o_charge_pump_boost) |-> since_load < 5'h10;
    endproperty
    a_pd_pump_off:
        assert property (p_pd_pump_off) else $error("pump driven in power-down");
    a_pd_no_lock:
        assert property (p_pd_no_lock) else $error("lock set in power-down");
    a_lock_needs_ref:
        assert property (p_lock_needs_ref) else $error("lock without enough reference edges");
    a_bias_no_dither:
        assert property (p_bias_no_dither) else $error("dither on in lowest noise mode");
    a_current_on_load:
        assert property (p_current_on_load) else $error("pump current changed without load");
    a_prescaler_on_load:
        assert property (p_prescaler_on_load) else $error("prescaler changed without load");
    a_pd_on_load:
        assert property (p_pd_on_load) else $error("power-down changed without load");
    a_boost_on_load:
        assert property (p_boost_on_load) else $error("boost rose without load");
    c_lock: cover property ($rose(o_lock_detect));
    c_boost_end: cover property ($fell(o_charge_pump_boost));
    c_power_down: cover property ($rose(o_power_down));
endmodule // sfn_program_registers_chk
bind sfn_program_registers sfn_program_registers_chk u_chk (
    .i_clock(i_clock), .i_reset(i_reset), .i_reference_input(i_reference_input),
    .i_load_enable(i_load_enable), .o_charge_pump_oe(o_charge_pump_oe),
    .o_charge_pump_current(o_charge_pump_current), .o_charge_pump_boost(o_charge_pump_boost),
    .o_charge_pump_noise_bias(o_charge_pump_noise_bias), .o_dither_enable(o_dither_enable),
    .o_prescaler_select(o_prescaler_select), .o_power_down(o_power_down),
    .o_lock_detect(o_lock_detect));
`default_nettype wire

// ==== dv/sfn_host_model.sv ====
// Host model that shifts words into the three-wire serial port
`default_nettype none
module sfn_host_model (
    input wire logic i_clock,
    output logic o_serial_clock,
    output logic o_serial_data,
    output logic o_load_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_serial_clock = 1'b0;
        o_serial_data = 1'b1;
        o_load_enable = 1'b0;
    end
    // Five clocks per level clears the design's three-flop pin filter
    task automatic hold();
        repeat (5) @(negedge i_clock);
    endtask
    task automatic send_word(input logic [23:0] word);
        for (int i = 23; i >= 0; i--) begin
            o_serial_data = word[i];
            hold();
            o_serial_clock = 1'b1;
            hold();
            o_serial_clock = 1'b0;
        end
        // Data line is left showing the inverse so a stale bit is never mistaken
        o_serial_data = ~word[0];
        o_load_enable = 1'b1;
        hold();
        o_load_enable = 1'b0;
        hold();
    endtask
endmodule // sfn_host_model
`default_nettype wire

// ==== dv/sfn_program_registers_tb_top.sv ====
// Self-checking bench for the synthesizer program register block
`default_nettype none
module sfn_program_registers_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock = 0, i_reset = 1, ref_in = 0, rf_in = 0;
    wire sck, sdi, lden, up, dn, oe, boost, bias, dith, pre, pd, lock, mon;
    wire [3:0] cur;
    int mismatches = 0, total_checks = 0, rc = 0, vc = 0;
    always #5 i_clock = ~i_clock;
    sfn_program_registers DUT (.i_clock(i_clock), .i_reset(i_reset), .i_serial_clock(sck),
        .i_serial_data(sdi), .i_load_enable(lden), .i_reference_input(ref_in),
        .i_rf_feedback_input(rf_in), .o_charge_pump_up(up), .o_charge_pump_down(dn),
        .o_charge_pump_oe(oe), .o_charge_pump_current(cur), .o_charge_pump_boost(boost),
        .o_charge_pump_noise_bias(bias), .o_dither_enable(dith), .o_prescaler_select(pre),
        .o_power_down(pd), .o_lock_detect(lock), .o_monitor_output(mon));
    sfn_host_model host (.i_clock(i_clock), .o_serial_clock(sck), .o_serial_data(sdi),
        .o_load_enable(lden));
    // Reference period 310 clocks; feedback phase accumulator wraps every 5 clocks
    // Pump up adds a step and pump down holds, so every pumped clock moves the feedback
    // phase by exactly one clock and errors of one or two clocks are still nulled
    wire [1:0] vstep = up ? 2'h2 : dn ? 2'h0 : 2'h1;
    always @(negedge i_clock) begin
        rc <= (rc == 154) ? 0 : rc + 1;
        ref_in <= (rc == 154) ? ~ref_in : ref_in;
        vc <= (vc + vstep >= 5) ? vc + vstep - 5 : vc + vstep;
        rf_in <= (vc + vstep >= 5) ? ~rf_in : rf_in;
    end
    function automatic logic [23:0] w_div(logic f, logic [8:0] n, logic [11:0] fr);
        return {f, n, fr, 2'b00};
    endfunction
    function automatic logic [23:0] w_ref(logic l, logic [2:0] m, logic p, logic [11:0] md);
        return {l, m, 1'b0, p, 4'h1, md, 2'b01};
    endfunction
    function automatic logic [23:0] w_ctl(logic [3:0] c, logic ld, logic pw, logic t, logic r);
        return {12'h000, 1'b0, c, 1'b1, ld, pw, t, r, 2'b10};
    endfunction
    function automatic logic [23:0] w_ns(logic [8:0] n);
        return {13'h0000, n, 2'b11};
    endfunction
    // Active reference edges every 155 clocks with the doubler, every 310 without
    function automatic int ref_pulses(logic d, int r, int span);
        return span / ((d ? 155 : 310) * r);
    endfunction
    task automatic count_pulses(input int span, output int n);
        n = 0;
        repeat (span) begin
            @(negedge i_clock);
            n += (mon === 1'b1) ? 1 : 0;
        end
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [23:0] w);
        host.send_word(w);
        repeat (3) @(negedge i_clock);
    endtask
    // Counts falling reference edges until lock, noting where the boost ended
    task automatic lock_wait(output int fe, output int fb);
        logic prev;
        prev = ref_in;
        fe = 0;
        fb = -1;
        for (int n = 0; n < 25000 && lock !== 1'b1; n++) begin
            @(negedge i_clock);
            fe += (prev && !ref_in) ? 1 : 0;
            if (boost !== 1'b1 && fb < 0) fb = fe;
            prev = ref_in;
        end
    endtask
    initial begin
        repeat (95000) @(posedge i_clock);
        mismatches++;
        $display("watchdog expired");
        summarize();
    end
    initial begin
        logic [3:0] c;
        logic b;
        logic [8:0] nz;
        int fe, fb, np;
        void'($urandom(32'h8a63));
        repeat (12) @(negedge i_clock);
        i_reset = 0;
        repeat (3) @(negedge i_clock);
        chk("oe after reset", 1, oe);
        for (int i = 0; i < 6; i++) begin
            c = 4'($urandom);
            b = 1'($urandom);
            wr(w_ctl(c, 0, i == 5, b, 1));
            chk("current", c, cur);
            chk("oe", !b && i != 5, oe);
            chk("power down", i == 5, pd);
        end
        $display("test control done");
        for (int i = 0; i < 3; i++) begin
            nz = (i == 0) ? 9'h000 : (i == 1) ? 9'h0F1 : 9'h100 | 9'($urandom);
            wr(i == 1 ? 24'h0003C7 : w_ns(nz));
            chk("dither", nz == 9'h000, dith);
            chk("bias", nz == 9'h0F1, bias);
        end
        for (int i = 0; i < 2; i++) begin
            wr(w_ref(0, 3'h0, i, 12'h041));
            chk("prescaler", i, pre);
            chk("monitor off", 0, mon);
        end
        $display("test modes done");
        wr(w_ns(9'h000));
        wr(24'h0003C7);
        wr(w_ctl(4'h7, 0, 0, 0, 1));
        wr(w_ref(1, 3'h0, 0, 12'h003));
        wr(w_ref(0, 3'h6, 0, 12'h041));
        wr(w_div(1, 9'h01F, 12'h000));
        wr(w_ctl(4'h7, 0, 0, 0, 0));
        chk("boost on", 1, boost);
        chk("monitor fast lock", 1, mon);
        lock_wait(fe, fb);
        chk("boost pulses", 3, 16'(fb));
        chk("lock", 1, lock);
        chk("lock short count", 1, fe >= 24);
        $display("test fast lock done");
        wr(w_ref(0, 3'h1, 0, 12'h041));
        chk("monitor lock", 1, mon);
        wr(w_div(0, 9'h01F, 12'h000));
        chk("lock after new channel", 0, lock);
        wr(w_ctl(4'h7, 1, 0, 0, 0));
        lock_wait(fe, fb);
        chk("lock", 1, lock);
        chk("lock long count", 1, fe >= 38);
        wr(w_ctl(4'h7, 1, 1, 0, 0));
        chk("lock in power down", 0, lock);
        chk("oe in power down", 0, oe);
        $display("test lock done");
        wr(w_ctl(4'h7, 0, 0, 0, 0) | 24'h000800);
        // Same reference word with R set to 3 and the divided reference on the monitor
        wr(w_ref(0, 3'h2, 0, 12'h041) ^ 24'h008000);
        count_pulses(930, np);
        chk("ref pulses doubled", ref_pulses(1, 3, 930), 16'(np));
        wr(w_ctl(4'h7, 0, 0, 0, 0));
        count_pulses(930, np);
        chk("ref pulses single", ref_pulses(0, 3, 930), 16'(np));
        $display("test reference divider done");
        summarize();
    end
endmodule // sfn_program_registers_tb_top
`default_nettype wire
